// File: inc/tic_cfg.svh
/*
  constants of the timer and external interrupt control block: register
  offset, bit positions, reset values and bus widths.
  assumes it is included by bare name from the package and the design.
*/
`ifndef TIC_CFG_SVH
`define TIC_CFG_SVH

`define TIC_ADDR_W          12
`define TIC_DATA_W          32
`define TIC_CTRL_OFS        12'h088
`define TIC_CTRL_RST        8'h00
`define TIC_BIT_T1_FLAG     7
`define TIC_BIT_T1_RUN      6
`define TIC_BIT_T0_FLAG     5
`define TIC_BIT_T0_RUN      4
`define TIC_BIT_X1_FLAG     3
`define TIC_BIT_X1_EDGE     2
`define TIC_BIT_X0_FLAG     1
`define TIC_BIT_X0_EDGE     0
`define TIC_SYNC_RST        2'h3

`endif

// File: inc/tic_pkg.sv
/*
  types of the timer and external interrupt control block.
  assumes tic_cfg.svh is reachable on the include path.
*/
`include "tic_cfg.svh"

package tic_pkg;

  // one bit per interrupt source, same order as the control register flags
  typedef struct packed {
    logic timer1;
    logic timer0;
    logic ext1;
    logic ext0;
  } tic_src_t;

  // apb transfer phase as seen by the slave
  typedef enum logic [2:0] {
    TIC_APB_IDLE   = 3'b001,
    TIC_APB_ACCESS = 3'b010,
    TIC_APB_DONE   = 3'b100
  } tic_apb_state_t;

endpackage

// File: rtl/tic_timer_irq_control.sv
/*
  timer run control, timer overflow flags and external interrupt flags,
  reached by software over an apb slave with one control register.
  assumes overflow pulses come from the timer datapaths, the cpu pulses one
  vector acknowledge per source, and pins are synchronous inputs that are
  still resynchronised here.
*/
//
// Contract
// RULE_01 - set timer 1 flag on overflow, hold
// RULE_02 - timer 1 flag cleared by software or vector
// RULE_03 - timer 1 run bit gates counting
// RULE_04 - set timer 0 flag on overflow, hold
// RULE_05 - timer 0 flag cleared by software or vector
// RULE_06 - timer 0 run bit gates counting
// RULE_07 - ext 1 flag set on chosen pin event
// RULE_08 - ext 1 vector clear only in edge mode
// RULE_09 - level mode ext 1 flag is inverted pin
// RULE_10 - ext 1 select: 0 level, 1 falling edge
// RULE_11 - ext 0 flag set on chosen pin event
// RULE_12 - ext 0 vector clear only in edge mode
// RULE_13 - level mode ext 0 flag is inverted pin
// RULE_14 - ext 0 select: 0 level, 1 falling edge
// RULE_15 - two-flop sync on both interrupt pins
// RULE_16 - request per set flag, ack clears
`include "tic_cfg.svh"

module tic_timer_irq_control #(
  parameter int ADDR_W = `TIC_ADDR_W
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_timer0_overflow,
  input  wire logic              i_timer1_overflow,
  input  wire logic              i_ext_irq0_pin_n,
  input  wire logic              i_ext_irq1_pin_n,
  input  wire tic_pkg::tic_src_t i_vector_ack,
  output logic                   o_timer0_run,
  output logic                   o_timer1_run,
  output tic_pkg::tic_src_t      o_irq_req
);
  import tic_pkg::*;

  // reset image of the control register, indexed per bit so no shift truncates
  localparam logic [7:0] CTRL_RST = `TIC_CTRL_RST;

  tic_apb_state_t apb_state;
  logic [1:0]     pin_meta;
  logic [1:0]     pin_sync;
  logic [1:0]     pin_prev;
  logic           timer1_overflow_flag;
  logic           timer1_run;
  logic           timer0_overflow_flag;
  logic           timer0_run;
  logic           ext_irq1_flag;
  logic           ext_irq1_edge_select;
  logic           ext_irq0_flag;
  logic           ext_irq0_edge_select;
  logic [7:0]     ctrl_value;
  logic           ctrl_hit;
  logic           ctrl_write;
  logic [1:0]     pin_fall;
  tic_src_t       next_flags;

  // register address match on every address bit, byte offset included
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    addr_is = (addr == ofs);
  endfunction

  // flag update: set beats any clear landing in the same cycle
  function automatic logic flag_next(input logic cur, input logic set, input logic wr,
                                     input logic wval, input logic ack);
    logic held;
    held = wr ? wval : cur;
    flag_next = set | (held & ~ack);
  endfunction

  assign ctrl_value = {timer1_overflow_flag, timer1_run, timer0_overflow_flag, timer0_run,
                       ext_irq1_flag, ext_irq1_edge_select, ext_irq0_flag, ext_irq0_edge_select};
  assign ctrl_hit   = addr_is(i_paddr, ADDR_W'(`TIC_CTRL_OFS));
  // writes land only on the completing access edge
  assign ctrl_write = (apb_state == TIC_APB_ACCESS) && i_psel && i_penable && i_pwrite
                      && ctrl_hit && i_pstrb[0];

  // apb slave, zero wait states; pready comes from a flop
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      apb_state <= TIC_APB_IDLE;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end
    else
    begin
      case (apb_state)
        TIC_APB_IDLE:
        begin
          if (i_psel && !i_penable)
          begin
            apb_state <= TIC_APB_ACCESS;
            o_pready  <= 1'b1;
            // unmapped address answers with an error and zero data
            if (ctrl_hit)
            begin
              o_pslverr <= 1'b0;
              o_prdata  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, ctrl_value};
            end
            else
            begin
              o_pslverr <= 1'b1;
              o_prdata  <= 32'h0000_0000;
            end
          end
        end
        TIC_APB_ACCESS:
        begin
          apb_state <= TIC_APB_DONE;
          o_pready  <= 1'b0;
          o_pslverr <= 1'b0;
          o_prdata  <= 32'h0000_0000;
        end
        TIC_APB_DONE:
        begin
          apb_state <= TIC_APB_IDLE;
        end
        default:
        begin
          apb_state <= TIC_APB_IDLE;
          o_pready  <= 1'b0;
        end
      endcase
    end
  end

  // first stage read only by the second; reset to idle-high pins
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      pin_meta <= `TIC_SYNC_RST;
      pin_sync <= `TIC_SYNC_RST;
      pin_prev <= `TIC_SYNC_RST;
    end
    else
    begin
      pin_meta <= {i_ext_irq1_pin_n, i_ext_irq0_pin_n};
      pin_sync <= pin_meta; // see RULE_15
      pin_prev <= pin_sync;
    end
  end

  assign pin_fall = pin_prev & ~pin_sync; // see RULE_15

  // run and type select bits are plain software state
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      timer1_run           <= CTRL_RST[`TIC_BIT_T1_RUN];
      timer0_run           <= CTRL_RST[`TIC_BIT_T0_RUN];
      ext_irq1_edge_select <= CTRL_RST[`TIC_BIT_X1_EDGE];
      ext_irq0_edge_select <= CTRL_RST[`TIC_BIT_X0_EDGE];
    end
    else if (ctrl_write)
    begin
      timer1_run           <= i_pwdata[`TIC_BIT_T1_RUN];
      timer0_run           <= i_pwdata[`TIC_BIT_T0_RUN];
      ext_irq1_edge_select <= i_pwdata[`TIC_BIT_X1_EDGE]; // see RULE_10
      ext_irq0_edge_select <= i_pwdata[`TIC_BIT_X0_EDGE]; // see RULE_14
    end
  end

  always_comb
  begin
    next_flags.timer1 = flag_next(timer1_overflow_flag, i_timer1_overflow, ctrl_write,
                                  i_pwdata[`TIC_BIT_T1_FLAG], i_vector_ack.timer1); // see RULE_01 see RULE_02
    next_flags.timer0 = flag_next(timer0_overflow_flag, i_timer0_overflow, ctrl_write,
                                  i_pwdata[`TIC_BIT_T0_FLAG], i_vector_ack.timer0); // see RULE_04 see RULE_05
    // level mode mirrors the pin, so software and vector clears have no lasting effect
    if (ext_irq1_edge_select)
      next_flags.ext1 = flag_next(ext_irq1_flag, pin_fall[1], ctrl_write,
                                  i_pwdata[`TIC_BIT_X1_FLAG], i_vector_ack.ext1); // see RULE_07 see RULE_08
    else
      next_flags.ext1 = ~pin_sync[1]; // see RULE_09
    if (ext_irq0_edge_select)
      next_flags.ext0 = flag_next(ext_irq0_flag, pin_fall[0], ctrl_write,
                                  i_pwdata[`TIC_BIT_X0_FLAG], i_vector_ack.ext0); // see RULE_11 see RULE_12
    else
      next_flags.ext0 = ~pin_sync[0]; // see RULE_13
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      timer1_overflow_flag <= CTRL_RST[`TIC_BIT_T1_FLAG];
      timer0_overflow_flag <= CTRL_RST[`TIC_BIT_T0_FLAG];
      ext_irq1_flag        <= CTRL_RST[`TIC_BIT_X1_FLAG];
      ext_irq0_flag        <= CTRL_RST[`TIC_BIT_X0_FLAG];
      o_irq_req            <= '0;
    end
    else
    begin
      timer1_overflow_flag <= next_flags.timer1;
      timer0_overflow_flag <= next_flags.timer0;
      ext_irq1_flag        <= next_flags.ext1;
      ext_irq0_flag        <= next_flags.ext0;
      o_irq_req            <= next_flags; // see RULE_16
    end
  end

  // run outputs mirror the run bits from their own flops
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_timer1_run <= 1'b0;
      o_timer0_run <= 1'b0;
    end
    else
    begin
      o_timer1_run <= ctrl_write ? i_pwdata[`TIC_BIT_T1_RUN] : timer1_run; // see RULE_03
      o_timer0_run <= ctrl_write ? i_pwdata[`TIC_BIT_T0_RUN] : timer0_run; // see RULE_06
    end
  end

endmodule // tic_timer_irq_control

// File: test/tic_timer_irq_control_chk.sv
/*
  port assertions for the timer and external interrupt control block.
  assumes it is bound onto tic_timer_irq_control.
*/
module tic_chk (
  input wire logic              i_core_clk,
  input wire logic              i_sys_rst,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [31:0]       i_pwdata,
  input wire logic [3:0]        i_pstrb,
  input wire logic              o_pready,
  input wire logic              i_timer0_overflow,
  input wire logic              i_timer1_overflow,
  input wire logic              i_ext_irq0_pin_n,
  input wire logic              i_ext_irq1_pin_n,
  input wire tic_pkg::tic_src_t i_vector_ack,
  input wire logic              o_timer0_run,
  input wire logic              o_timer1_run,
  input wire tic_pkg::tic_src_t o_irq_req
);
  timeunit 1ns;
  timeprecision 1ns;
  import tic_pkg::*;
  logic e0;
  logic e1;
  // unmapped writes are never issued, so no address decode here
  wire wr = i_psel && i_penable && i_pwrite && o_pready && i_pstrb[0];
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst) {e1, e0} <= 2'h0;
    else if (wr) {e1, e0} <= {i_pwdata[2], i_pwdata[0]};
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  property p_t1_set; i_timer1_overflow |=> o_irq_req.timer1; endproperty
  a_t1_set: assert property (p_t1_set) else $error("t1 flag");
  property p_t1_clr; i_vector_ack.timer1 && !i_timer1_overflow && !wr |=> !o_irq_req.timer1; endproperty
  a_t1_clr: assert property (p_t1_clr) else $error("t1 ack");
  property p_run1; wr |=> o_timer1_run == $past(i_pwdata[6]); endproperty
  a_run1: assert property (p_run1) else $error("run1");
  property p_t0_set; i_timer0_overflow |=> o_irq_req.timer0; endproperty
  a_t0_set: assert property (p_t0_set) else $error("t0 flag");
  property p_t0_clr; i_vector_ack.timer0 && !i_timer0_overflow && !wr |=> !o_irq_req.timer0; endproperty
  a_t0_clr: assert property (p_t0_clr) else $error("t0 ack");
  property p_run0; wr |=> o_timer0_run == $past(i_pwdata[4]); endproperty
  a_run0: assert property (p_run0) else $error("run0");
  property p_x1_lvl; !e1 && !$past(e1) && !$past(wr) && !$past(i_sys_rst, 3)
    |-> o_irq_req.ext1 == !$past(i_ext_irq1_pin_n, 3); endproperty
  a_x1_lvl: assert property (p_x1_lvl) else $error("x1 level");
  property p_x0_lvl; !e0 && !$past(e0) && !$past(wr) && !$past(i_sys_rst, 3)
    |-> o_irq_req.ext0 == !$past(i_ext_irq0_pin_n, 3); endproperty
  a_x0_lvl: assert property (p_x0_lvl) else $error("x0 level");
  property p_x0_edge; e0 && $past(e0, 5) && $past(i_ext_irq0_pin_n, 5) && !$past(i_ext_irq0_pin_n, 4)
    && !$past(i_sys_rst, 5) |-> o_irq_req.ext0; endproperty
  a_x0_edge: assert property (p_x0_edge) else $error("x0 edge");
  property p_x0_ack; e0 && i_vector_ack.ext0 && !wr && $past(i_ext_irq0_pin_n, 2) |=> !o_irq_req.ext0; endproperty
  a_x0_ack: assert property (p_x0_ack) else $error("x0 ack");
endmodule // tic_chk

bind tic_timer_irq_control tic_chk u_chk (.i_core_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_pwdata,
  .i_pstrb, .o_pready, .i_timer0_overflow, .i_timer1_overflow, .i_ext_irq0_pin_n, .i_ext_irq1_pin_n,
  .i_vector_ack, .o_timer0_run, .o_timer1_run, .o_irq_req);

// File: test/tic_cpu_model.sv
/*
  cpu vectoring model: acks each enabled pending request, never on two cycles in a row.
  assumes the bench picks which sources get vectored.
*/
module tic_cpu_model (
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire tic_pkg::tic_src_t i_irq_req,
  input  wire tic_pkg::tic_src_t i_auto_ack,
  output tic_pkg::tic_src_t      o_vector_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  import tic_pkg::*;
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst) o_vector_ack <= '0;
    // no ack twice in a row: the flag needs a cycle to drop
    else o_vector_ack <= i_irq_req & i_auto_ack & ~o_vector_ack;
  end
endmodule // tic_cpu_model

// File: test/tic_timer_irq_control_tb_top.sv
/*
  self-checking bench for the control block.
  assumes the checker is bound and the cpu model answers vectors.
*/
module tic_timer_irq_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tic_pkg::*;
`define CHK(nm, ex, gt) n_compared++; if ((gt) !== (ex)) begin errors++; $display("MISMATCH %s %h %h", nm, ex, gt); end
  localparam logic [11:0] CTRL = 12'h088;
  logic        clk, rst, psel, penable, pwrite, ovf0, ovf1, pin0_n, pin1_n, pready, rerr, run0, run1;
  logic        rerr_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0]  pstrb;
  tic_src_t    ack, req, auto_ack;
  int          errors, n_compared;
  logic [15:0] rows [5] = '{16'h5050, 16'h0505, 16'hffff, 16'h0a00, 16'h0000};
  tic_timer_irq_control u_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(rerr), .i_timer0_overflow(ovf0), .i_timer1_overflow(ovf1),
    .i_ext_irq0_pin_n(pin0_n), .i_ext_irq1_pin_n(pin1_n), .i_vector_ack(ack), .o_timer0_run(run0),
    .o_timer1_run(run1), .o_irq_req(req));
  tic_cpu_model u_cpu (.i_core_clk(clk), .i_sys_rst(rst), .i_irq_req(req), .i_auto_ack(auto_ack),
    .o_vector_ack(ack));
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic final_report;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin errors++; final_report(); end
    rdata = prdata;
    rerr_q = rerr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  initial
  begin
    {rst, ovf0, ovf1, pin0_n, pin1_n} = 5'h13;
    {psel, penable, pwrite, paddr, pwdata, pstrb, auto_ack} = '0;
    repeat (20) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    apb(0, CTRL, 8'h00, 4'hf);
    `CHK("reset", 32'h0, rdata)
    apb(0, 12'h08c, 8'h00, 4'hf);
    `CHK("unmapped", 33'h100000000, {rerr_q, rdata})
    apb(1, CTRL, 8'h50, 4'he);
    apb(0, CTRL, 8'h00, 4'hf);
    `CHK("strobe", 8'h00, rdata[7:0])
    for (int i = 0; i < 5; i++)
    begin
      apb(1, CTRL, rows[i][15:8], 4'hf);
      apb(0, CTRL, 8'h00, 4'hf);
      `CHK("ctrl", rows[i][7:0], rdata[7:0])
      `CHK("runs", {rows[i][14], rows[i][12]}, {run1, run0})
      `CHK("req", {rows[i][7], rows[i][5], rows[i][3], rows[i][1]}, req)
    end
    for (int t = 0; t < 2; t++)
    begin
      {ovf1, ovf0} <= t ? 2'h2 : 2'h1;
      @(posedge clk);
      {ovf1, ovf0} <= 2'h0;
      apb(0, CTRL, 8'h00, 4'hf);
      `CHK("tflag", t ? 8'h80 : 8'h20, rdata[7:0])
      auto_ack <= t ? 4'h8 : 4'h4;
      repeat (4) @(posedge clk);
      auto_ack <= 4'h0;
      apb(0, CTRL, 8'h00, 4'hf);
      `CHK("tclear", 8'h00, rdata[7:0])
    end
    pin1_n <= 0;
    repeat (5) @(posedge clk);
    apb(0, CTRL, 8'h00, 4'hf);
    `CHK("level", 8'h08, rdata[7:0])
    pin1_n <= 1;
    // let the level flag drop before edge mode holds it
    repeat (4) @(posedge clk);
    apb(1, CTRL, 8'h05, 4'hf);
    {pin1_n, pin0_n} <= 2'h0;
    @(posedge clk);
    {pin1_n, pin0_n} <= 2'h3;
    repeat (5) @(posedge clk);
    apb(0, CTRL, 8'h00, 4'hf);
    `CHK("edge", 8'h0f, rdata[7:0])
    auto_ack <= 4'h3;
    repeat (4) @(posedge clk);
    auto_ack <= 4'h0;
    apb(0, CTRL, 8'h00, 4'hf);
    `CHK("eclear", 8'h05, rdata[7:0])
    apb(1, CTRL, 8'hff, 4'hf);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    `CHK("rst_req", 4'h0, req)
    `CHK("rst_run", 2'h0, {run1, run0})
    apb(0, CTRL, 8'h00, 4'hf);
    `CHK("rst_ctrl", 32'h0, rdata)
    final_report();
  end
endmodule // tic_timer_irq_control_tb_top
